// ### src/adc_decimator_and_init.sv
// Decimation chain, serial port synchronisation and register port of the converter.
module adc_decimator_and_init #(
    parameter int MOD_DIV = adc_filter_pkg::MOD_DIV,
    parameter int FILT_W = adc_filter_pkg::FILT_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire adc_filter_pkg::reg_req_t bus_req,
    output logic [adc_filter_pkg::DATA_W-1:0] rdata_q,
    input wire adc_filter_pkg::serial_pins_t port_pins,
    input wire logic mod_bit,
    output logic cmd_valid_q,
    output logic [7:0] cmd_byte_q,
    output logic word_valid_q,
    output logic [adc_filter_pkg::WORD_W-1:0] word_q,
    output logic base_rate_select_q,
    output logic reference_range_select_q
);

    localparam int RW = adc_filter_pkg::RATIO_W;
    localparam int NS = adc_filter_pkg::S5_SECTIONS;

    if (MOD_DIV < 2 || FILT_W < 48) begin : g_bad
        $error("MOD_DIV must be at least 2 and FILT_W at least 48");
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Word rates halve per index step from the base rate, so the base rate
    // over the word rate is a power of two for either base-rate select.
    function automatic logic [RW-1:0] ratio_of(input logic [adc_filter_pkg::RATE_W-1:0] idx);
        ratio_of = RW'(1) << idx;
    endfunction : ratio_of

    function automatic logic [adc_filter_pkg::RATE_W-1:0] clamp_rate(
        input logic [adc_filter_pkg::RATE_W-1:0] idx);
        clamp_rate = (idx > adc_filter_pkg::RATE_IDX_MAX) ? adc_filter_pkg::RATE_IDX_MAX : idx;
    endfunction : clamp_rate

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;
    logic sclk_prev_q;
    logic mod_meta_q;
    logic mod_sync_q;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_q <= 3'h2;
            pin_sync_q <= 3'h2;
            sclk_prev_q <= 1'b0;
            mod_meta_q <= 1'b0;
            mod_sync_q <= 1'b0;
        end
        else
        begin
            pin_meta_q <= {port_pins.sclk, port_pins.cs_n, port_pins.sdi};
            pin_sync_q <= pin_meta_q;
            sclk_prev_q <= pin_sync_q[2];
            mod_meta_q <= mod_bit;
            mod_sync_q <= mod_meta_q;
        end
    end

    logic sclk_rise;
    logic sdi_bit;
    assign sclk_rise = pin_sync_q[2] && !sclk_prev_q && !pin_sync_q[1];
    assign sdi_bit = pin_sync_q[0];

    // ------------------------------------------------------------------
    // Serial port synchronisation and command bytes
    // ------------------------------------------------------------------
    // The ones counter ignores byte framing, so the host can recover a
    // port that has lost its bit alignment.
    logic [adc_filter_pkg::ONES_W-1:0] ones_q;
    logic [6:0] shift_q;
    logic [2:0] bit_cnt_q;
    logic cmd_mode_q;
    logic sync_active_q;
    logic term_seen;
    logic [7:0] rx_byte;

    assign term_seen = sclk_rise && !sdi_bit && (ones_q >= adc_filter_pkg::ONES_NEEDED);
    assign rx_byte = {shift_q, sdi_bit};

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ones_q <= '0;
        end
        else if (sclk_rise)
        begin
            if (!sdi_bit)
            begin
                ones_q <= '0;
            end
            else if (ones_q != '1)
            begin
                ones_q <= ones_q + adc_filter_pkg::ONES_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_q <= '0;
            bit_cnt_q <= '0;
            cmd_mode_q <= 1'b0;
            sync_active_q <= 1'b0;
            cmd_valid_q <= 1'b0;
            cmd_byte_q <= '0;
        end
        else
        begin
            cmd_valid_q <= 1'b0;
            if (term_seen)
            begin
                cmd_mode_q <= 1'b1;
                sync_active_q <= 1'b0;
                bit_cnt_q <= '0;
                shift_q <= '0;
            end
            else if (sclk_rise)
            begin
                shift_q <= rx_byte[6:0];
                bit_cnt_q <= bit_cnt_q + 3'h1;
                if (bit_cnt_q == 3'h7)
                begin
                    if (rx_byte == adc_filter_pkg::SYNC_ONES_BYTE)
                    begin
                        sync_active_q <= 1'b1;
                    end
                    else if (cmd_mode_q && !sync_active_q)
                    begin
                        cmd_valid_q <= 1'b1;
                        cmd_byte_q <= rx_byte;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic [adc_filter_pkg::DATA_W-1:0] ctrl_q;
    logic [adc_filter_pkg::RATE_W-1:0] rate_idx;
    logic [adc_filter_pkg::CH_W-1:0] chan;
    logic [adc_filter_pkg::CH_W-1:0] new_chan;
    logic ctrl_wr;

    assign ctrl_wr = bus_req.wr && (bus_req.addr == adc_filter_pkg::CTRL_OFS);
    assign rate_idx = clamp_rate(ctrl_q[adc_filter_pkg::CTRL_RATE_LSB +: adc_filter_pkg::RATE_W]);
    assign chan = ctrl_q[adc_filter_pkg::CTRL_CH_LSB +: adc_filter_pkg::CH_W];
    assign new_chan = bus_req.wdata[adc_filter_pkg::CTRL_CH_LSB +: adc_filter_pkg::CH_W];

    // Conversions run from the reset setup until software writes one.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= adc_filter_pkg::CTRL_RESET;
            base_rate_select_q <= 1'b0;
            reference_range_select_q <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            ctrl_q <= bus_req.wdata;
            base_rate_select_q <= bus_req.wdata[adc_filter_pkg::CTRL_FRS_BIT];
            reference_range_select_q <= bus_req.wdata[adc_filter_pkg::CTRL_VRS_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Flush and ratio tracking
    // ------------------------------------------------------------------
    logic chan_flush_q;
    logic [RW-1:0] ratio_q;
    logic ratio_restart;
    logic [RW-1:0] ratio;

    assign ratio = ratio_of(rate_idx);
    assign ratio_restart = (ratio != ratio_q);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chan_flush_q <= 1'b0;
            ratio_q <= RW'(1);
        end
        else
        begin
            chan_flush_q <= ctrl_wr && (new_chan != chan);
            ratio_q <= ratio;
        end
    end

    // ------------------------------------------------------------------
    // Modulator rate and fifth-order stage
    // ------------------------------------------------------------------
    // Every stage is clocked by core_clk and advanced only by this enable,
    // so all word rates move with the master clock.
    logic [$clog2(MOD_DIV)-1:0] div_q;
    logic mod_en_q;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_q <= '0;
            mod_en_q <= 1'b0;
        end
        else
        begin
            mod_en_q <= (div_q == ($clog2(MOD_DIV))'(MOD_DIV - 1));
            div_q <= (div_q == ($clog2(MOD_DIV))'(MOD_DIV - 1)) ? '0
                : div_q + ($clog2(MOD_DIV))'(1);
        end
    end

    logic [NS:0] s_valid;
    logic signed [FILT_W-1:0] s_data [NS+1];

    assign s_valid[0] = mod_en_q;
    assign s_data[0] = mod_sync_q ? FILT_W'(1) : -FILT_W'(1);

    for (genvar g = 0; g < NS; g++) begin : g_sinc5
        cic_stage #(
            .ORDER(adc_filter_pkg::S5_ORDER[g]),
            .W(FILT_W),
            .RW(RW)
        ) u_section (
            .clk(core_clk),
            .rst_n(rst_n),
            .restart(chan_flush_q),
            .ratio(RW'(adc_filter_pkg::S5_RATIO[g])),
            .in_valid(s_valid[g]),
            .in_data(s_data[g]),
            .out_valid(s_valid[g+1]),
            .out_data(s_data[g+1])
        );
    end

    // ------------------------------------------------------------------
    // Third-order stage
    // ------------------------------------------------------------------
    logic s3_valid;
    logic signed [FILT_W-1:0] s3_data;
    logic bypass;

    assign bypass = (rate_idx == '0);

    cic_stage #(
        .ORDER(3),
        .W(FILT_W),
        .RW(RW)
    ) u_sinc3 (
        .clk(core_clk),
        .rst_n(rst_n),
        .restart(chan_flush_q || ratio_restart),
        .ratio(ratio),
        .in_valid(s_valid[NS] && !bypass),
        .in_data(s_data[NS]),
        .out_valid(s3_valid),
        .out_data(s3_data)
    );

    // ------------------------------------------------------------------
    // Output word
    // ------------------------------------------------------------------
    // The third-order gain is the ratio cubed, a power of two, so a shift
    // restores the fifth-order scale, rounding toward minus infinity.
    logic new_word;
    logic signed [FILT_W-1:0] pick;
    logic signed [FILT_W-1:0] scaled;
    logic word_ready_q;
    logic data_rd;

    assign new_word = bypass ? s_valid[NS] : s3_valid;
    assign pick = bypass ? s_data[NS] : s3_data;
    assign scaled = pick >>> (3 * rate_idx);
    assign data_rd = bus_req.rd && (bus_req.addr == adc_filter_pkg::DATA_OFS);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            word_valid_q <= 1'b0;
            word_q <= '0;
            word_ready_q <= 1'b0;
        end
        else
        begin
            word_valid_q <= new_word && !ratio_restart;
            if (new_word && !ratio_restart)
            begin
                word_q <= scaled[adc_filter_pkg::WORD_W-1:0];
            end
            if (new_word && !ratio_restart)
            begin
                word_ready_q <= 1'b1;
            end
            else if (data_rd)
            begin
                word_ready_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= '0;
            if (bus_req.rd)
            begin
                case (bus_req.addr)
                    adc_filter_pkg::CTRL_OFS: rdata_q <= ctrl_q;
                    adc_filter_pkg::STATUS_OFS:
                    begin
                        rdata_q[adc_filter_pkg::STAT_CMD_BIT] <= cmd_mode_q;
                        rdata_q[adc_filter_pkg::STAT_SYNC_BIT] <= sync_active_q;
                        rdata_q[adc_filter_pkg::STAT_READY_BIT] <= word_ready_q;
                    end
                    adc_filter_pkg::DATA_OFS:
                    begin
                        rdata_q[adc_filter_pkg::DATA_WORD_LSB +: adc_filter_pkg::WORD_W] <= word_q;
                        rdata_q[adc_filter_pkg::CH_W-1:0] <= chan;
                    end
                    adc_filter_pkg::CMD_OFS: rdata_q[7:0] <= cmd_byte_q;
                    default: rdata_q <= '0;
                endcase
            end
        end
    end

endmodule : adc_decimator_and_init

// ### src/adc_filter_pkg.sv
// Shared constants and carriers for the converter's filter back end and port.
package adc_filter_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] DATA_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] CMD_OFS = 8'h0c;
    localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
    localparam int CTRL_FRS_BIT = 0;
    localparam int CTRL_VRS_BIT = 1;
    localparam int CTRL_RATE_LSB = 2;
    localparam int RATE_W = 4;
    localparam int CTRL_CH_LSB = 6;
    localparam int CH_W = 2;
    localparam int STAT_CMD_BIT = 0;
    localparam int STAT_SYNC_BIT = 1;
    localparam int STAT_READY_BIT = 2;
    localparam int DATA_WORD_LSB = 8;
    localparam logic [RATE_W-1:0] RATE_IDX_MAX = 4'h9;

    // ------------------------------------------------------------------
    // Serial port synchronisation
    // ------------------------------------------------------------------
    localparam logic [7:0] SYNC_ONES_BYTE = 8'hff;
    localparam logic [7:0] SYNC_TERM_BYTE = 8'hfe;
    localparam int SYNC_ONES_COUNT = 15;
    localparam int ONES_W = 7;
    localparam logic [ONES_W-1:0] ONES_NEEDED = ONES_W'(SYNC_ONES_COUNT * 8 + 7);

    // ------------------------------------------------------------------
    // Filter structure
    // ------------------------------------------------------------------
    localparam int MOD_DIV = 16;
    localparam int FILT_W = 56;
    localparam int WORD_W = 24;
    localparam int RATIO_W = 10;
    localparam int S5_SECTIONS = 4;
    localparam int S5_ORDER [S5_SECTIONS] = '{3, 2, 3, 5};
    localparam int S5_RATIO [S5_SECTIONS] = '{2, 2, 4, 5};

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic sdi;
    } serial_pins_t;

endpackage : adc_filter_pkg

// ### src/cic_stage.sv
// One comb-integrator decimating section with runtime ratio and flush.
module cic_stage #(
    parameter int ORDER = 3,
    parameter int W = 56,
    parameter int RW = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic [RW-1:0] ratio,
    input wire logic in_valid,
    input wire logic signed [W-1:0] in_data,
    output logic out_valid,
    output logic signed [W-1:0] out_data
);

    logic signed [W-1:0] integ_q [ORDER];
    logic signed [W-1:0] comb_q [ORDER];
    logic signed [W-1:0] diff [ORDER];
    logic [RW-1:0] cnt_q;
    logic hit;

    if (ORDER < 1 || RW < 1) begin : g_bad
        $error("cic_stage needs ORDER and RW of at least one");
    end

    assign hit = in_valid && (cnt_q >= ratio - RW'(1));

    always_comb
    begin
        for (int k = 0; k < ORDER; k++)
        begin
            diff[k] = (k == 0 ? integ_q[ORDER-1] : diff[k == 0 ? 0 : k-1]) - comb_q[k];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int k = 0; k < ORDER; k++)
            begin
                integ_q[k] <= '0;
                comb_q[k] <= '0;
            end
            cnt_q <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end
        else if (restart)
        begin
            for (int k = 0; k < ORDER; k++)
            begin
                integ_q[k] <= '0;
                comb_q[k] <= '0;
            end
            cnt_q <= '0;
            out_valid <= 1'b0;
        end
        else
        begin
            out_valid <= hit;
            if (in_valid)
            begin
                integ_q[0] <= integ_q[0] + in_data;
                for (int k = 1; k < ORDER; k++)
                begin
                    integ_q[k] <= integ_q[k] + integ_q[k-1];
                end
                cnt_q <= hit ? '0 : cnt_q + RW'(1);
            end
            if (hit)
            begin
                comb_q[0] <= integ_q[ORDER-1];
                for (int k = 1; k < ORDER; k++)
                begin
                    comb_q[k] <= diff[k-1];
                end
                out_data <= diff[ORDER-1];
            end
        end
    end

endmodule : cic_stage

// ### verification/adc_decimator_and_init_props.sv
// Concurrent checks on the ports of the converter back end.
module adc_decimator_and_init_props #(
    parameter int MOD_DIV = 16
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire adc_filter_pkg::reg_req_t bus_req,
    input wire logic [adc_filter_pkg::DATA_W-1:0] rdata_q,
    input wire adc_filter_pkg::serial_pins_t port_pins,
    input wire logic mod_bit,
    input wire logic cmd_valid_q,
    input wire logic [7:0] cmd_byte_q,
    input wire logic word_valid_q,
    input wire logic [adc_filter_pkg::WORD_W-1:0] word_q,
    input wire logic base_rate_select_q,
    input wire logic reference_range_select_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ------
    // Helper logic
    // ------
    // A setup write may restart or flush the chain, and one word from the old history may
    // still leave, so the period check re-arms only two words after the write.
    logic [31:0] gap_q;
    logic [3:0] idx_q, cs_hi_q;
    logic [1:0] armed_q;
    wire ctrl_wr = bus_req.wr && bus_req.addr == adc_filter_pkg::CTRL_OFS;
    wire [31:0] period = 32'(80 * MOD_DIV) << idx_q;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gap_q <= '0;
            idx_q <= '0;
            armed_q <= 2'h0;
            cs_hi_q <= '0;
        end
        else
        begin
            gap_q <= word_valid_q ? 32'h0 : gap_q + 32'h1;
            armed_q <= ctrl_wr ? 2'h0 : armed_q + 2'(word_valid_q && armed_q != 2'h2);
            cs_hi_q <= !port_pins.cs_n ? 4'h0 : (cs_hi_q == 4'hf ? cs_hi_q : cs_hi_q + 4'h1);
            if (ctrl_wr)
                idx_q <= bus_req.wdata[5:2] > 4'h9 ? 4'h9 : bus_req.wdata[5:2];
        end
    end
    // ------
    // Properties
    // ------
    sequence s_ctrl_write;
        bus_req.wr && bus_req.addr == adc_filter_pkg::CTRL_OFS;
    endsequence
    sequence s_quiet_8(sig);
        !sig [*8];
    endsequence
    property p_rdata_idle;
        !$past(bus_req.rd) |-> rdata_q == '0;
    endproperty
    property p_frs_copy;
        s_ctrl_write |=> base_rate_select_q == $past(bus_req.wdata[0]);
    endproperty
    property p_ref_copy;
        s_ctrl_write |=> reference_range_select_q == $past(bus_req.wdata[1]);
    endproperty
    property p_sel_hold;
        !ctrl_wr |=> $stable({base_rate_select_q, reference_range_select_q});
    endproperty
    property p_word_pulse;
        word_valid_q |=> s_quiet_8(word_valid_q);
    endproperty
    property p_word_hold;
        !word_valid_q |-> $stable(word_q);
    endproperty
    property p_word_period;
        word_valid_q && armed_q == 2'h2 |-> gap_q == period - 32'h1;
    endproperty
    property p_cmd_pulse;
        cmd_valid_q |=> s_quiet_8(cmd_valid_q);
    endproperty
    property p_cmd_hold;
        !cmd_valid_q |-> $stable(cmd_byte_q);
    endproperty
    property p_cmd_framed;
        cmd_valid_q |-> cs_hi_q < 4'hc;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    a_frs_copy: assert property (p_frs_copy) else $error("base select not copied");
    a_ref_copy: assert property (p_ref_copy) else $error("range select not copied");
    a_sel_hold: assert property (p_sel_hold) else $error("select moved alone");
    a_word_pulse: assert property (p_word_pulse) else $error("word pulse too long");
    a_word_hold: assert property (p_word_hold) else $error("word changed alone");
    a_word_period: assert property (p_word_period) else $error("word period wrong");
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse too long");
    a_cmd_hold: assert property (p_cmd_hold) else $error("command byte moved");
    a_cmd_framed: assert property (p_cmd_framed) else $error("command while deselected");
    c_period: cover property (word_valid_q && armed_q == 2'h2);
endmodule : adc_decimator_and_init_props

bind adc_decimator_and_init adc_decimator_and_init_props #(.MOD_DIV(MOD_DIV)) props_inst (
    .core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req), .rdata_q(rdata_q),
    .port_pins(port_pins), .mod_bit(mod_bit), .cmd_valid_q(cmd_valid_q),
    .cmd_byte_q(cmd_byte_q), .word_valid_q(word_valid_q), .word_q(word_q),
    .base_rate_select_q(base_rate_select_q),
    .reference_range_select_q(reference_range_select_q));

// ### verification/host_port_model.sv
// Host side of the three-wire port: start-up wait, sync pattern and command bytes.
module host_port_model #(
    parameter int STARTUP_CYCLES = 20,
    parameter int HALF = 4,
    parameter logic [7:0] RESET_CMD = 8'h80
) (
    input wire logic core_clk,
    output var adc_filter_pkg::serial_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // The serial clock stands low between frames; a released data line is inverted.
    initial pins = '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b1};
    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk);
    endtask : wait_clk
    task automatic startup();
        wait_clk(STARTUP_CYCLES);
    endtask : startup
    task automatic send_byte(input logic [7:0] b);
        wait_clk(1);
        pins.cs_n <= 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            pins.sdi <= b[i];
            wait_clk(HALF);
            pins.sclk <= 1'b1;
            wait_clk(HALF);
            pins.sclk <= 1'b0;
        end
    endtask : send_byte
    task automatic end_frame();
        wait_clk(HALF);
        pins.cs_n <= 1'b1;
        pins.sdi <= ~pins.sdi;
    endtask : end_frame
    task automatic sync_port();
        repeat (15) send_byte(8'hff);
        send_byte(8'hfe);
        end_frame();
    endtask : sync_port
    task automatic sys_reset();
        send_byte(RESET_CMD);
        end_frame();
    endtask : sys_reset
endmodule : host_port_model

// ### verification/adc_decimator_and_init_tb.sv
// Self-checking bench for the decimator, serial sync and register port.
module adc_decimator_and_init_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // A short sample divider keeps the run brief; every word period checked below derives from it.
    localparam int MOD_DIV = 2;
    localparam logic [23:0] FULL_POS = 24'h61a800;
    localparam logic [23:0] FULL_NEG = 24'h9e5800;
    logic core_clk, rst_n, mod_bit, cmd_valid_q, word_valid_q;
    logic base_rate_select_q, reference_range_select_q;
    logic [7:0] cmd_byte_q;
    logic [23:0] word_q;
    logic [31:0] rdata_q, d;
    adc_filter_pkg::reg_req_t bus_req;
    adc_filter_pkg::serial_pins_t port_pins;
    int n_fail = 0, total_checks = 0, n_cmd = 0, n0, gap;
    adc_decimator_and_init #(.MOD_DIV(MOD_DIV)) adc_decimator_and_init_inst (
        .core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req), .rdata_q(rdata_q),
        .port_pins(port_pins), .mod_bit(mod_bit), .cmd_valid_q(cmd_valid_q),
        .cmd_byte_q(cmd_byte_q), .word_valid_q(word_valid_q), .word_q(word_q),
        .base_rate_select_q(base_rate_select_q),
        .reference_range_select_q(reference_range_select_q));
    host_port_model host_port_model_inst (.core_clk(core_clk), .pins(port_pins));
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
        if (cmd_valid_q === 1'b1)
            n_cmd++;
    // ------
    // Shared tasks
    // ------
    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_eq
    task automatic check_flag(input logic got);
        total_checks++;
        if (got !== 1'b1)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, 1'b1);
        end
    endtask : check_flag
    task automatic bus_write(input logic [7:0] a, input logic [31:0] w);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask : bus_write
    task automatic bus_read(input logic [7:0] a, output logic [31:0] r);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1 r = rdata_q;
    endtask : bus_read
    task automatic wait_word(output int g);
        g = 0;
        do
        begin
            @(posedge core_clk);
            #1 g++;
        end while (word_valid_q !== 1'b1 && g < 5000);
    endtask : wait_word
    // ------
    // Scenarios
    // ------
    task automatic t_reset_state();
        bus_read(adc_filter_pkg::CTRL_OFS, d);
        check_eq(d, adc_filter_pkg::CTRL_RESET);
        bus_write(adc_filter_pkg::STATUS_OFS, 32'hffff_ffff);
        bus_read(adc_filter_pkg::STATUS_OFS, d);
        check_eq(32'(d[0]), 32'h0);
        bus_read(8'h10, d);
        check_eq(d, 32'h0);
        n0 = n_cmd;
        host_port_model_inst.send_byte(8'h03);
        host_port_model_inst.end_frame();
        repeat (8) @(posedge core_clk);
        check_eq(n_cmd, n0);
    endtask : t_reset_state
    task automatic t_sync();
        n0 = n_cmd;
        host_port_model_inst.sync_port();
        repeat (8) @(posedge core_clk);
        check_eq(n_cmd, n0);
        bus_read(adc_filter_pkg::STATUS_OFS, d);
        check_eq(32'(d[1:0]), 32'h1);
        host_port_model_inst.sys_reset();
        repeat (8) @(posedge core_clk);
        check_eq(n_cmd, n0 + 1);
        check_eq(32'(cmd_byte_q), 32'h80);
        bus_read(adc_filter_pkg::CMD_OFS, d);
        check_eq(d, 32'h80);
    endtask : t_sync
    task automatic t_selects();
        for (int s = 0; s < 4; s++)
        begin
            bus_write(adc_filter_pkg::CTRL_OFS, 32'(s));
            bus_read(adc_filter_pkg::CTRL_OFS, d);
            check_eq(d, 32'(s));
            check_eq(32'(base_rate_select_q), 32'(s % 2));
            check_eq(32'(reference_range_select_q), 32'(s / 2));
        end
    endtask : t_selects
    task automatic t_rates();
        for (int i = 0; i < 3; i++)
        begin
            bus_write(adc_filter_pkg::CTRL_OFS, 32'(i * 4 + i % 2));
            repeat (8) wait_word(gap);
            wait_word(gap);
            check_eq(gap, (80 * MOD_DIV) << i);
            check_eq(32'(word_q), 32'(FULL_POS));
        end
        @(posedge core_clk);
        mod_bit <= 1'b0;
        repeat (9) wait_word(gap);
        check_eq(32'(word_q), 32'(FULL_NEG));
        @(posedge core_clk);
        mod_bit <= 1'b1;
    endtask : t_rates
    task automatic t_flush();
        bus_write(adc_filter_pkg::CTRL_OFS, 32'h0);
        repeat (9) wait_word(gap);
        bus_write(adc_filter_pkg::CTRL_OFS, 32'h40);
        repeat (2) wait_word(gap);
        check_flag(word_q !== FULL_POS);
        repeat (9) wait_word(gap);
        bus_read(adc_filter_pkg::STATUS_OFS, d);
        check_eq(32'(d[2]), 32'h1);
        bus_read(adc_filter_pkg::DATA_OFS, d);
        check_eq(d, {FULL_POS, 8'h01});
        bus_read(adc_filter_pkg::STATUS_OFS, d);
        check_eq(32'(d[2]), 32'h0);
        bus_write(adc_filter_pkg::CTRL_OFS, 32'h40);
        repeat (2) wait_word(gap);
        check_eq(32'(word_q), 32'(FULL_POS));
    endtask : t_flush
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    initial
    begin
        bus_req = '0;
        mod_bit = 1'b1;
        rst_n = 1'b0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        host_port_model_inst.startup();
        t_reset_state();
        t_sync();
        t_selects();
        t_rates();
        t_flush();
        final_report();
    end
    initial
    begin
        repeat (40000) @(posedge core_clk);
        n_fail++;
        final_report();
    end
endmodule : adc_decimator_and_init_tb
